// file: src/mit_pkg.sv
// Shared types and constants for the instruction timing and execution core
package mit_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int         CLOCKS_PER_CYCLE = 4;     // System clocks in one instruction cycle
  localparam logic [1:0] PHASE_LAST       = 2'h3;  // Phase that closes an instruction cycle
  localparam logic [1:0] PHASE_FETCHED    = 2'h1;  // Phase whose end captures the fetched word

  // ************************************************************
  // Widths, addresses and reset values
  // ************************************************************
  localparam int          PC_W        = 11;       // Program counter width
  localparam int          INSN_W      = 16;       // Instruction word width
  localparam int          STACK_DEPTH = 4;        // Return address slots
  localparam int          SP_W        = 2;        // Stack pointer width
  localparam logic [10:0] PC_RESET    = 11'h000;  // Program counter after reset
  localparam logic [7:0]  ACC_RESET   = 8'h00;    // Accumulator after reset
  localparam logic [7:0]  PCL_ADDR    = 8'h02;    // Data address of the low PC byte
  localparam logic [2:0]  TABLE_PAGE  = 3'h7;     // Program page holding fixed tables

  // ************************************************************
  // Opcodes, field [15:11] of the instruction word
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_MOVAM, OP_MOVMA, OP_MOVAI,
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_ADDI, OP_SUBI, OP_ANDI, OP_ORI,
    OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC,
    OP_SET, OP_CLR, OP_SZ, OP_SBZ, OP_SBNZ,
    OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT, OP_TABRD, OP_HALT, OP_CLRWDT
  } mit_op_e;

  // Core sequencing states
  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_SLEEP} mit_state_e;

  // Data memory request, registered
  typedef struct packed {
    logic       we;     // Write strobe, one clock
    logic [7:0] addr;   // Data address
    logic [7:0] wdata;  // Write data
  } mit_dmem_s;

  // Visible flags
  typedef struct packed {
    logic gie;    // Global interrupt enable
    logic zero;   // Zero flag
    logic carry;  // Carry, or borrow after subtraction
  } mit_status_s;

endpackage : mit_pkg

// file: src/mit_alu.sv
// Arithmetic, logic and rotate unit of the core
`timescale 1ns/1ps
`default_nettype none
module mit_alu
  import mit_pkg::*;
(
  input  wire mit_op_e    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            carry_we
);

  // ************************************************************
  // Operation select
  // ************************************************************
  // Pure combinational; the caller decides where the result goes
  always_comb begin
    result    = operand;
    carry_out = carry_in;
    carry_we  = 1'b0;
    case (op)
      OP_ADD, OP_ADDI: begin                  // Carry out past 255
        {carry_out, result} = {1'b0, acc} + {1'b0, operand};
        carry_we            = 1'b1;
      end
      OP_SUB, OP_SUBI: begin                  // Borrow when below zero
        result    = acc - operand;
        carry_out = acc < operand;
        carry_we  = 1'b1;
      end
      OP_AND, OP_ANDI: result = acc & operand;
      OP_OR, OP_ORI:   result = acc | operand;
      OP_XOR:          result = acc ^ operand;
      OP_CPL:          result = ~operand;
      OP_INC:          result = operand + 8'h01;
      OP_DEC:          result = operand - 8'h01;
      OP_RR:           result = {operand[0], operand[7:1]};
      OP_RL:           result = {operand[6:0], operand[7]};
      OP_RRC: begin                           // Bit 0 leaves into carry
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
        carry_we  = 1'b1;
      end
      OP_RLC: begin                           // Bit 7 leaves into carry
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
        carry_we  = 1'b1;
      end
      OP_MOVMA:        result = acc;
      default:         result = operand;      // Moves into the accumulator
    endcase
  end

endmodule : mit_alu
`default_nettype wire

// file: src/mit_core.sv
// Instruction sequencing core with four-clock instruction cycles
// What this block does
// RL1 - Four system clocks make one instruction cycle
// RL2 - Branch, call, table read take two cycles
// RL3 - Writing low PC byte, except by table read, jumps, costs two cycles
// RL4 - Taken skip costs one extra cycle
// RL5 - Skips test memory zero or one bit
// RL6 - Add carries past 255, subtract borrows below 0
// RL7 - Step up/down by one, memory or accumulator
// RL8 - Logic results through accumulator set zero flag
// RL9 - Rotates move one bit, carry variants too
// RL10 - Call saves next address, exit returns there
// RL11 - Unconditional branch saves no return address
// RL12 - Bit set/clear keeps other seven bits
// RL13 - Moves: memory to acc, acc to memory, immediate
// RL14 - Table read fetches program memory into data
// RL15 - Power-down instruction sleeps; watchdog clear instruction
// RL16 - Interrupt exit sets global enable; plain exit not
// RL17 - Second cycle holds off the next instruction
`timescale 1ns/1ps
`default_nettype none
module mit_core
  import mit_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  output logic [PC_W-1:0]        prog_addr,
  input  wire logic [INSN_W-1:0] prog_rdata,
  output var mit_dmem_s          dmem,
  input  wire logic [7:0]        dmem_rdata,
  input  wire logic              wake_pin,
  output logic                   power_down,
  output logic                   wdt_clear,
  output var mit_status_s        status
);

  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic [1:0]      phase_q;                    // System clock within the cycle
  mit_state_e      state_q;                    // Run, second cycle or asleep
  logic [15:0]     ir_q;                       // Current instruction
  logic [PC_W-1:0] pc_q;                       // Program counter
  logic [PC_W-1:0] pc_d;                       // Next program counter
  logic [PC_W-1:0] stack_q [STACK_DEPTH];      // Return addresses
  logic [SP_W-1:0] sp_q;                       // Next free stack slot
  logic [7:0]      acc_q;                      // Accumulator
  logic            carry_q, zero_q, gie_q;     // Flags
  logic [7:0]      tab_q;                      // Table word low byte
  logic            wake_meta_q, wake_sync_q;   // Wake pin synchroniser
  mit_op_e         op;                         // Decoded opcode
  logic [7:0]      mdata, operand, alu_res, wval, mask;
  logic            alu_c, alu_cwe, cycle_en, exec, dummy_end;
  logic            mem_dest, acc_dest, pcl_write, skip_taken, is_skip, two_cycle;

  // One-hot mask of the addressed bit
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  assign op        = mit_op_e'(ir_q[15:11]);
  assign cycle_en  = (phase_q == PHASE_LAST);                          // RL1
  assign exec      = cycle_en && (state_q == ST_RUN);
  assign dummy_end = cycle_en && (state_q == ST_DUMMY);
  assign mask      = bit_mask(ir_q[10:8]);
  // Low PC byte reads back from the counter, not the memory
  assign mdata     = (dmem.addr == PCL_ADDR) ? pc_q[7:0] : dmem_rdata;
  assign operand   = (op inside {OP_MOVAI, OP_ADDI, OP_SUBI, OP_ANDI, OP_ORI})
                     ? ir_q[7:0] : mdata;

  mit_alu u_alu (
    .op        (op),
    .acc       (acc_q),
    .operand   (operand),
    .carry_in  (carry_q),
    .result    (alu_res),
    .carry_out (alu_c),
    .carry_we  (alu_cwe)
  );

  // ************************************************************
  // Destination and timing decode
  // ************************************************************
  // Bit 8 picks the accumulator for two-operand and unary forms
  always_comb begin
    wval = alu_res;
    if (op == OP_SET) begin
      wval = mdata | mask;                                             // RL12
    end else if (op == OP_CLR) begin
      wval = mdata & ~mask;                                            // RL12
    end
    mem_dest = (op inside {OP_MOVMA, OP_SET, OP_CLR}) ||               // RL13
               ((op inside {[OP_ADD:OP_XOR], [OP_CPL:OP_RLC]}) && !ir_q[8]);
    acc_dest = (op inside {OP_MOVAM, OP_MOVAI, [OP_ADDI:OP_ORI]}) ||   // RL8
               ((op inside {[OP_ADD:OP_XOR], [OP_CPL:OP_RLC]}) && ir_q[8]);
    pcl_write = mem_dest && (ir_q[7:0] == PCL_ADDR);                   // RL3
    is_skip   = op inside {OP_SZ, OP_SBZ, OP_SBNZ};
    case (op)                                                          // RL5
      OP_SZ:   skip_taken = (mdata == 8'h00);
      OP_SBZ:  skip_taken = !mdata[ir_q[10:8]];
      OP_SBNZ: skip_taken = mdata[ir_q[10:8]];
      default: skip_taken = 1'b0;
    endcase
    two_cycle = (op inside {OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT, OP_TABRD}) // RL2
                || pcl_write || skip_taken;                            // RL4
  end

  // Next program counter; a skip steps over one word
  always_comb begin
    pc_d = pc_q + 11'h001;
    case (op)
      OP_JMP, OP_CALL: pc_d = ir_q[10:0];                              // RL11
      OP_RET, OP_INTERRUPT_EXIT: pc_d = stack_q[sp_q - 2'h1];                    // RL10
      default:         pc_d = pc_q + 11'h001;
    endcase
    if (skip_taken) begin
      pc_d = pc_q + 11'h002;                                           // RL4
    end else if (pcl_write) begin
      pc_d = {pc_q[10:8], wval};                                       // RL3
    end
  end

  // ************************************************************
  // Sequencing
  // ************************************************************
  // Free-running four-clock phase counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;                                       // RL1
    end
  end

  // Wake pin is asynchronous, two flops before use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  // State changes only at instruction cycle boundaries
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else if (exec) begin
      if (op == OP_HALT) begin
        state_q <= ST_SLEEP;                                           // RL15
      end else if (two_cycle) begin
        state_q <= ST_DUMMY;                                           // RL17
      end
    end else if (dummy_end) begin
      state_q <= ST_RUN;
    end else if (cycle_en && (state_q == ST_SLEEP) && wake_sync_q) begin
      state_q <= ST_RUN;                // Wake resumes after the halt
    end
  end

  // ************************************************************
  // Fetch and program counter
  // ************************************************************
  // Instruction latched two clocks after its address is set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ir_q  <= 16'h0000;
      tab_q <= 8'h00;
    end else if (phase_q == PHASE_FETCHED) begin
      if (state_q == ST_RUN) begin
        ir_q <= prog_rdata;
      end else if (state_q == ST_DUMMY) begin
        tab_q <= prog_rdata[7:0];                                      // RL14
      end
    end
  end

  // Program address; table read borrows the second cycle's fetch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prog_addr <= PC_RESET;
      pc_q      <= PC_RESET;
    end else if (exec) begin
      pc_q      <= pc_d;
      prog_addr <= (op == OP_TABRD) ? {TABLE_PAGE, acc_q} : pc_d;      // RL14
    end else if (dummy_end) begin
      prog_addr <= pc_q;
    end
  end

  // Return stack; overflow wraps and overwrites the oldest entry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= PC_RESET;
      end
    end else if (exec && (op == OP_CALL)) begin
      stack_q[sp_q] <= pc_q + 11'h001;                                 // RL10
      sp_q          <= sp_q + 2'h1;
    end else if (exec && (op inside {OP_RET, OP_INTERRUPT_EXIT})) begin
      sp_q <= sp_q - 2'h1;                                             // RL10
    end
  end

  // ************************************************************
  // Accumulator and flags
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_q   <= ACC_RESET;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
      gie_q   <= 1'b0;
    end else if (exec) begin
      if (acc_dest) begin
        acc_q <= wval;                                                 // RL13
      end
      if (alu_cwe) begin
        carry_q <= alu_c;                                              // RL6 RL9
      end
      // Moves, bit ops and rotates leave the zero flag alone
      if (op inside {[OP_ADD:OP_DEC]}) begin
        zero_q <= (wval == 8'h00);                                     // RL8
      end
      if (op == OP_INTERRUPT_EXIT) begin
        gie_q <= 1'b1;                                                 // RL16
      end
    end
  end

  // ************************************************************
  // Data memory port and side pulses
  // ************************************************************
  // Write lands in phase 0 of the next cycle, ahead of its read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dmem      <= '0;
      wdt_clear <= 1'b0;
    end else begin
      dmem.we   <= 1'b0;
      wdt_clear <= exec && (op == OP_CLRWDT);                          // RL15
      if ((phase_q == PHASE_FETCHED) && (state_q == ST_RUN)) begin
        dmem.addr <= prog_rdata[7:0];
      end
      if (exec && mem_dest && !pcl_write) begin
        dmem.we    <= 1'b1;                                            // RL7 RL12
        dmem.wdata <= wval;
      end else if (dummy_end && (op == OP_TABRD)) begin
        dmem.we    <= 1'b1;                                            // RL14
        dmem.wdata <= tab_q;
      end
    end
  end

  assign power_down = (state_q == ST_SLEEP);                           // RL15
  assign status     = '{gie: gie_q, zero: zero_q, carry: carry_q};

  // ************************************************************
  // Checks
  // ************************************************************
  logic [8:0] sum9;
  assign sum9 = {1'b0, acc_q} + {1'b0, operand};

  property p_cycle_len; // RL1
    @(posedge clock) disable iff (!rstn)
      cycle_en |=> !cycle_en [*3] ##1 cycle_en;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not four clocks"); // RL1

  property p_jmp_two; // RL2
    @(posedge clock) disable iff (!rstn)
      (exec && op == OP_JMP) |=> (state_q == ST_DUMMY) [*4] ##1 (state_q == ST_RUN);
  endproperty
  a_jmp_two: assert property (p_jmp_two) else $error("branch not two cycles"); // RL2

  property p_pcl_jump; // RL3
    @(posedge clock) disable iff (!rstn)
      (exec && pcl_write) |=> state_q == ST_DUMMY && pc_q[7:0] == $past(wval);
  endproperty
  a_pcl_jump: assert property (p_pcl_jump) else $error("low pc write not a jump"); // RL3

  property p_noskip_one; // RL4
    @(posedge clock) disable iff (!rstn)
      (exec && is_skip && !skip_taken) |=> state_q == ST_RUN && pc_q == $past(pc_q) + 11'h001;
  endproperty
  a_noskip_one: assert property (p_noskip_one) else $error("untaken skip slow"); // RL4

  property p_add_carry; // RL6
    @(posedge clock) disable iff (!rstn)
      (exec && op inside {OP_ADD, OP_ADDI}) |=> carry_q == $past(sum9[8]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong"); // RL6

  property p_zero_flag; // RL8
    @(posedge clock) disable iff (!rstn)
      (exec && op inside {[OP_AND:OP_XOR]}) |=> zero_q == ($past(wval) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RL8

  property p_call_save; // RL10
    @(posedge clock) disable iff (!rstn)
      (exec && op == OP_CALL) |=> stack_q[sp_q - 2'h1] == $past(pc_q) + 11'h001;
  endproperty
  a_call_save: assert property (p_call_save) else $error("return address lost"); // RL10

  property p_jmp_nosave; // RL11
    @(posedge clock) disable iff (!rstn)
      (exec && op == OP_JMP) |=> pc_q == $past(ir_q[10:0]) && sp_q == $past(sp_q);
  endproperty
  a_jmp_nosave: assert property (p_jmp_nosave) else $error("branch touched stack"); // RL11

  property p_bit_set; // RL12
    @(posedge clock) disable iff (!rstn)
      (exec && op == OP_SET && !pcl_write) |=>
        dmem.we && dmem.wdata == ($past(mdata) | $past(mask));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set disturbed bits"); // RL12

  property p_exit_gie; // RL16
    @(posedge clock) disable iff (!rstn)
      (exec && op == OP_RET) |=> gie_q == $past(gie_q);
  endproperty
  a_exit_gie: assert property (p_exit_gie) else $error("plain exit changed enable"); // RL16

  property p_hold_off; // RL17
    @(posedge clock) disable iff (!rstn)
      (state_q == ST_DUMMY) |-> !dmem.we && $stable(ir_q);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("second cycle executed"); // RL17

endmodule : mit_core
`default_nettype wire

// file: verification/mit_mem.sv
// Program and data memory model standing on the far side of the core
`timescale 1ns/1ps
`default_nettype none
module mit_mem
  import mit_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [PC_W-1:0]   prog_addr,
  output logic [INSN_W-1:0]      prog_rdata,
  input  wire mit_dmem_s         dmem,
  output logic [7:0]             dmem_rdata
);
  // ************************************************************
  // Storage, preloaded by the bench through hierarchy
  // ************************************************************
  logic [INSN_W-1:0] prog_q [2**PC_W];  // Program words, tables in the top page
  logic [7:0]        data_q [256];      // Data bytes

  // Synchronous program read, one clock late; word stays valid from p1 through the next p0
  always @(posedge clock) begin
    prog_rdata <= prog_q[prog_addr];
  end

  // Data read and one-clock write strobe; a read at the write edge sees old data
  always @(posedge clock) begin
    dmem_rdata <= data_q[dmem.addr];
    if (dmem.we) begin
      data_q[dmem.addr] <= dmem.wdata;
    end
  end
endmodule : mit_mem
`default_nettype wire

// file: verification/mit_core_tb.sv
// Bench running a fixed program on random data against a shadow machine
`timescale 1ns/1ps
`default_nettype none
module mit_core_tb
  import mit_pkg::*;
;
  // ************************************************************
  // Signals and shadow state
  // ************************************************************
  logic              clock;       // System clock
  logic              rstn;        // Reset, active low
  logic              wake_pin;    // Wake request
  logic [PC_W-1:0]   prog_addr;   // Program address
  logic [INSN_W-1:0] prog_rdata;  // Program word
  mit_dmem_s         dmem;        // Data request
  logic [7:0]        dmem_rdata;  // Data read value
  logic              power_down;  // Asleep
  logic              wdt_clear;   // Watchdog service pulse
  mit_status_s       status;      // Flags
  int                fail_count;  // Mismatches
  int                n_tests;     // Comparisons
  logic [15:0]       pm [2**PC_W];  // Own copy of the program
  logic [7:0]        em [256];    // Expected data memory
  logic [7:0]        acc;         // Expected accumulator
  logic              c, z, gie;   // Expected flags
  logic [10:0]       pc, npc;     // Current and next address
  logic [10:0]       stk [$];     // Return addresses, never deep here
  int                cyc;         // Clocks the instruction should take
  int                gap;         // Clocks expected since the last address change

  mit_core dut_u (
    .clock      (clock),
    .rstn       (rstn),
    .prog_addr  (prog_addr),
    .prog_rdata (prog_rdata),
    .dmem       (dmem),
    .dmem_rdata (dmem_rdata),
    .wake_pin   (wake_pin),
    .power_down (power_down),
    .wdt_clear  (wdt_clear),
    .status     (status)
  );
  mit_mem mem_u (
    .clock      (clock),
    .prog_addr  (prog_addr),
    .prog_rdata (prog_rdata),
    .dmem       (dmem),
    .dmem_rdata (dmem_rdata)
  );

  always #10 clock = ~clock;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic put(input logic [10:0] a, input mit_op_e op, input logic [2:0] f,
                     input logic [7:0] m);
    pm[a] = {op, f, m};
    mem_u.prog_q[a] = {op, f, m};
  endtask : put

  // A write to the low PC byte redirects the program instead of storing
  task automatic wr(input logic [7:0] m, input logic [7:0] v);
    if (m == PCL_ADDR) begin
      npc = {pc[10:8], v};
      cyc = 8;
    end else begin
      em[m] = v;
    end
  endtask : wr

  task automatic res(input logic [7:0] m, input logic to_acc, input logic [7:0] v);
    if (to_acc) begin
      acc = v;
    end else begin
      wr(m, v);
    end
  endtask : res

  // Expected effect of one instruction word on the shadow state
  task automatic iss(input logic [15:0] w);
    mit_op_e    op;
    logic [7:0] v;
    logic [7:0] o;
    logic [8:0] r;
    logic       imm;
    logic       sk;
    op  = mit_op_e'(w[15:11]);
    v   = em[w[7:0]];
    imm = op inside {[OP_ADDI:OP_ORI]};
    o   = imm ? w[7:0] : v;
    r   = 9'h000;
    sk  = 1'b0;
    npc = pc + 11'h1;
    cyc = 4;
    case (op)
      OP_MOVAM: acc = v;
      OP_MOVMA: wr(w[7:0], acc);
      OP_MOVAI: acc = w[7:0];
      OP_ADD, OP_ADDI: r = {1'b0, acc} + {1'b0, o};
      OP_SUB, OP_SUBI: r = {1'b0, acc} - {1'b0, o};
      OP_AND, OP_ANDI: r = {1'b0, acc & o};
      OP_OR, OP_ORI: r = {1'b0, acc | o};
      OP_XOR: r = {1'b0, acc ^ o};
      OP_CPL: r = {1'b0, ~v};
      OP_INC: r = {1'b0, v + 8'h01};
      OP_DEC: r = {1'b0, v - 8'h01};
      OP_RR: o = {v[0], v[7:1]};
      OP_RL: o = {v[6:0], v[7]};
      OP_RRC: o = {c, v[7:1]};
      OP_RLC: o = {v[6:0], c};
      OP_SET: wr(w[7:0], v | (8'h01 << w[10:8]));
      OP_CLR: wr(w[7:0], v & ~(8'h01 << w[10:8]));
      OP_SZ: sk = (v == 8'h00);
      OP_SBZ: sk = !v[w[10:8]];
      OP_SBNZ: sk = v[w[10:8]];
      OP_JMP, OP_CALL: begin
        if (op == OP_CALL) stk.push_back(npc);
        npc = w[10:0];
        cyc = 8;
      end
      OP_RET, OP_INTERRUPT_EXIT: begin
        npc = stk.pop_back();
        gie = gie | (op == OP_INTERRUPT_EXIT);
        cyc = 8;
      end
      OP_TABRD: begin
        wr(w[7:0], pm[{TABLE_PAGE, acc}][7:0]);
        cyc = 8;
      end
      default: ;
    endcase
    if (op inside {[OP_ADD:OP_DEC]}) begin
      z = (r[7:0] == 8'h00);
      if (op inside {OP_ADD, OP_ADDI, OP_SUB, OP_SUBI}) c = r[8];
      res(w[7:0], imm | w[8], r[7:0]);
    end
    if (op inside {[OP_RR:OP_RLC]}) begin
      if (op == OP_RRC) c = v[0];
      if (op == OP_RLC) c = v[7];
      res(w[7:0], w[8], o);
    end
    if (sk) begin
      npc = pc + 11'h2;
      cyc = 8;
    end
  endtask : iss

  // Waits for the next address change; a hang shows as a wrong count
  task automatic step(input logic [10:0] exp_pc, input int exp_n);
    logic [10:0] last;
    int          n;
    last = prog_addr;
    n    = 0;
    do begin
      tick();
      n++;
    end while (prog_addr === last && n < 20);
    check("prog_addr", 16'(prog_addr), 16'(exp_pc));
    check("clocks", 16'(n), 16'(exp_n));
    check("status", 16'(status), 16'({gie, z, c}));
    if (n >= 20) stop_test();
  endtask : step

  // ************************************************************
  // Main sequence: three rounds, each after a fresh reset
  // ************************************************************
  initial begin
    int n;
    clock = 1'b0;
    rstn = 1'b0;
    wake_pin = 1'b0;
    fail_count = 0;
    n_tests = 0;
    void'($urandom(29));
    put(0, OP_MOVAM, 0, 8'h10);
    put(1, OP_ADD, 0, 8'h11);
    put(2, OP_SUB, 1, 8'h11);
    put(3, OP_RLC, 0, 8'h12);
    put(4, OP_ANDI, 0, 8'h00);
    put(5, OP_CALL, 0, 8'h20);
    put(6, OP_SZ, 0, 8'h13);
    put(7, OP_MOVAI, 0, 8'hff);  // Skipped over
    put(8, OP_SBNZ, 5, 8'h13);
    put(9, OP_MOVAI, 0, 8'h30);
    put(10, OP_MOVMA, 0, 8'h02);
    put(11'h20, OP_SET, 3, 8'h12);
    put(11'h21, OP_CLR, 0, 8'h12);
    put(11'h22, OP_INC, 1, 8'h12);
    put(11'h23, OP_RL, 0, 8'h17);
    put(11'h24, OP_RRC, 1, 8'h15);
    put(11'h25, OP_RET, 0, 8'h00);
    put(11'h30, OP_TABRD, 0, 8'h14);
    put(11'h31, OP_CALL, 0, 8'h40);
    put(11'h32, OP_CLRWDT, 0, 8'h00);
    put(11'h33, OP_JMP, 0, 8'h50);
    put(11'h40, OP_INTERRUPT_EXIT, 0, 8'h00);
    put(11'h50, OP_ORI, 0, 8'h0f);
    put(11'h51, OP_XOR, 1, 8'h12);
    put(11'h52, OP_CPL, 0, 8'h15);
    put(11'h53, OP_DEC, 0, 8'h16);
    put(11'h54, OP_RR, 1, 8'h17);
    put(11'h55, OP_SBZ, 4, 8'h17);
    put(11'h56, OP_MOVMA, 0, 8'h18);
    put(11'h57, OP_ADDI, 0, 8'hf0);
    put(11'h58, OP_SUBI, 0, 8'h9c);
    put(11'h59, OP_AND, 1, 8'h11);
    put(11'h5a, OP_OR, 0, 8'h19);
    put(11'h5b, OP_HALT, 0, 8'h00);
    put(11'h5c, OP_JMP, 0, 8'h5c);
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      rstn = 1'b0;
      for (int i = 0; i < 256; i++) begin
        em[i] = 8'($urandom);
      end
      em[8'h13] = 8'h00;  // Zero so the skip is taken
      em[8'h16] = 8'h01;  // Step down reaches zero
      foreach (em[i]) mem_u.data_q[i] = em[i];
      put(11'h730, mit_op_e'(5'($urandom)), 3'($urandom), 8'($urandom));
      acc = ACC_RESET;
      {gie, z, c} = 3'h0;
      pc = PC_RESET;
      stk.delete();
      gap = 4;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      for (int s = 0; s < 64 && pm[pc][15:11] != OP_HALT; s++) begin
        iss(pm[pc]);
        // Table read shows the table address during its second cycle
        if (pm[pc][15:11] == OP_TABRD) begin
          step({TABLE_PAGE, acc}, gap);
          gap = 4;
        end
        // Target shows at once; the second cycle lengthens the next gap
        step(npc, gap);
        check("wdt_clear", 16'(wdt_clear), 16'(pm[pc][15:11] == OP_CLRWDT));
        gap = (pm[pc][15:11] == OP_TABRD) ? 4 : cyc;
        pc = npc;
      end
      // Sleep, stay asleep, then wake and carry on after the halt
      n = 0;
      while (power_down !== 1'b1 && n < 8) begin
        tick();
        n++;
      end
      check("power_down", 16'(power_down), 16'h1);
      if (n >= 8) stop_test();
      repeat (6) tick();
      check("power_down", 16'(power_down), 16'h1);
      @(negedge clock);
      wake_pin = 1'b1;
      n = 0;
      while (power_down !== 1'b0 && n < 16) begin
        tick();
        n++;
      end
      check("power_down", 16'(power_down), 16'h0);
      if (n >= 16) stop_test();
      repeat (8) tick();
      check("prog_addr", 16'(prog_addr), 16'(pc + 11'h1));
      @(negedge clock);
      wake_pin = 1'b0;
      for (int i = 0; i < 256; i++) begin
        check("data", 16'(mem_u.data_q[i]), 16'(em[i]));
      end
    end
    stop_test();
  end
endmodule : mit_core_tb
`default_nettype wire
